//--- rtl/pllld_defines.svh
// Offsets, field positions, reset values and timing counts of the lock detector
`ifndef PLLLD_DEFINES_SVH
`define PLLLD_DEFINES_SVH
// Register offsets
`define PLLLD_OFS_LD_CFG 8'h07
`define PLLLD_OFS_PIN_CFG 8'h0f
`define PLLLD_OFS_STATUS 8'h12
// Reset values
`define PLLLD_LD_CFG_RST 24'h00014d
`define PLLLD_PIN_CFG_RST 24'h000001
// Field positions
`define PLLLD_STATUS_LOCK_BIT 1
`define PLLLD_PIN_SEL_LOCK 5'h01
`define PLLLD_PIN_SEL_TIMER 5'h02
// Required hit counts per code
`define PLLLD_HITS_0 17'h00005
`define PLLLD_HITS_1 17'h00020
`define PLLLD_HITS_2 17'h00060
`define PLLLD_HITS_3 17'h00100
`define PLLLD_HITS_4 17'h00200
`define PLLLD_HITS_5 17'h00800
`define PLLLD_HITS_6 17'h02000
`define PLLLD_HITS_7 17'h0ffff
// Timing
`define PLLLD_CLK_PERIOD_NS 20
`define PLLLD_ANALOG_WIN_NS 10
`define PLLLD_CYC_OF_TENTHS(t) (((t) / (`PLLLD_CLK_PERIOD_NS * 10)) > 0 ? ((t) / (`PLLLD_CLK_PERIOD_NS * 10)) : 1)
`define PLLLD_ANALOG_WIN_CYC `PLLLD_CYC_OF_TENTHS(`PLLLD_ANALOG_WIN_NS * 10)
`endif

//--- rtl/pllld_lock_detector.sv
// Digital lock detector with register port and shared lock/serial-out pin
`timescale 1ns/1ns
`default_nettype none
`include "pllld_defines.svh"

// Behaviour
// - Enable bit gates all lock detection
// - Only arrival difference magnitude is measured
// - Lock after consecutive in-window comparisons
// - Hit code decodes to 5..65535 hits
// - Window bit selects analog 10ns or digital
// - Duration field sets timer window cycles
// - Speed field sets lock timer rate
// - Lock timer clock observable on test pin
// - Window length follows speed-duration matrix
// - Lock flag readable in status register
// - Lock source drives pin with lock
// - Pin shows read data during reads
module pllld_lock_detector
  import pllld_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Phase comparator edges, asynchronous: bit 0 reference, bit 1 divided oscillator
  input wire logic [1:0] phase_comparator_edge_i,
  // Register port from the serial engine
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  output logic [23:0] reg_rdata_o,
  // Serial read data from the serial engine
  input wire logic sdo_read_active_i,
  input wire logic sdo_data_i,
  // Pins
  output logic lock_or_serial_out_pin_o,
  output logic gpo_test_o,
  output logic lock_indicator_o
);

  // Digital window matrix in tenths of ns, index {speed, duration}
  localparam logic [11:0] WIN_TENTHS [32] = '{
    12'd65, 12'd80, 12'd110, 12'd170, 12'd290, 12'd530, 12'd1000, 12'd1950,
    12'd70, 12'd89, 12'd128, 12'd210, 12'd360, 12'd680, 12'd1300, 12'd2550,
    12'd71, 12'd92, 12'd133, 12'd220, 12'd380, 12'd720, 12'd1380, 12'd2720,
    12'd76, 12'd102, 12'd154, 12'd260, 12'd470, 12'd880, 12'd1720, 12'd3380};
  localparam logic [5:0] ANALOG_CYC = 6'(`PLLLD_ANALOG_WIN_CYC);

  pllld_cfg_t cfg_reg; // Lock detect configuration
  pllld_pin_cfg_t pin_cfg_reg; // Pin routing
  pllld_state_t state_reg, state_next; // Comparison state
  logic [1:0] sync_meta_reg, sync_reg, prev_reg; // Edge synchronisers
  logic [5:0] diff_reg, diff_next; // Cycles since first edge
  logic [15:0] hit_cnt_reg, hit_cnt_next; // Consecutive hits
  logic lock_reg, lock_next; // Lock flag
  logic [1:0] ring_div_reg; // Lock timer divider
  logic ring_clk_reg; // Lock timer clock model
  logic pin_reg; // Registered shared pin
  logic gpo_reg; // Registered test pin
  logic [23:0] rdata_reg; // Read data

  // Decoded wires
  wire logic ref_rise = sync_reg[0] & ~prev_reg[0];
  wire logic div_rise = sync_reg[1] & ~prev_reg[1];
  wire logic [11:0] win_tenths = WIN_TENTHS[{cfg_reg.timer_speed, cfg_reg.win_duration}];
  wire logic [5:0] digital_cyc = 6'(`PLLLD_CYC_OF_TENTHS(win_tenths));
  wire logic [5:0] win_cyc = cfg_reg.digital_win ? digital_cyc : ANALOG_CYC;
  wire logic [6:0] arrival = {1'b0, diff_reg} + 7'h01;
  // Required consecutive hits for the programmed code
  wire logic [16:0] hit_need =
    (cfg_reg.hit_code == 3'h0) ? `PLLLD_HITS_0 :
    (cfg_reg.hit_code == 3'h1) ? `PLLLD_HITS_1 :
    (cfg_reg.hit_code == 3'h2) ? `PLLLD_HITS_2 :
    (cfg_reg.hit_code == 3'h3) ? `PLLLD_HITS_3 :
    (cfg_reg.hit_code == 3'h4) ? `PLLLD_HITS_4 :
    (cfg_reg.hit_code == 3'h5) ? `PLLLD_HITS_5 :
    (cfg_reg.hit_code == 3'h6) ? `PLLLD_HITS_6 : `PLLLD_HITS_7;
  // Write decode; the status offset has no write path
  wire logic wr_cfg = reg_wr_i && (reg_addr_i == `PLLLD_OFS_LD_CFG);
  wire logic wr_pin = reg_wr_i && (reg_addr_i == `PLLLD_OFS_PIN_CFG);
  wire logic [23:0] status_word = 24'(lock_reg) << `PLLLD_STATUS_LOCK_BIT;
  // Read selection; unmapped offsets read zero
  wire logic [23:0] rd_mux =
    (reg_addr_i == `PLLLD_OFS_LD_CFG) ? cfg_reg :
    (reg_addr_i == `PLLLD_OFS_PIN_CFG) ? pin_cfg_reg :
    (reg_addr_i == `PLLLD_OFS_STATUS) ? status_word : 24'h000000;
  // Shared pin and test pin sources
  wire logic pin_lock_sel = (pin_cfg_reg.out_sel == `PLLLD_PIN_SEL_LOCK);
  wire logic pin_serial = ~pin_cfg_reg.share_off & sdo_read_active_i;
  wire logic pin_value = pin_serial ? sdo_data_i : (pin_lock_sel & lock_reg);
  wire logic gpo_value = (pin_cfg_reg.out_sel == `PLLLD_PIN_SEL_TIMER) & ring_clk_reg;

  // Comparison and hit counting
  always_comb begin
    logic hit;
    logic miss;
    hit = 1'b0;
    miss = 1'b0;
    state_next = state_reg;
    diff_next = diff_reg;
    unique case (state_reg)
      PLLLD_IDLE: begin
        // Waiting for the first edge of a comparison
        diff_next = 6'h00;
        // Either edge may come first; only the gap counts
        if (ref_rise && div_rise) begin
          hit = 1'b1;
        end else if (ref_rise) begin
          state_next = PLLLD_WAIT_DIV;
        end else if (div_rise) begin
          state_next = PLLLD_WAIT_REF;
        end
      end
      PLLLD_WAIT_DIV, PLLLD_WAIT_REF: begin
        // A comparison is open; count the gap
        diff_next = arrival[5:0];
        if ((state_reg == PLLLD_WAIT_DIV) ? div_rise : ref_rise) begin
          // Partner edge arrived
          hit = (arrival < {1'b0, win_cyc});
          miss = ~hit;
          state_next = PLLLD_IDLE;
        end else if (ref_rise || div_rise || (arrival >= {1'b0, win_cyc})) begin
          // Same edge twice or window expired
          miss = 1'b1;
          state_next = PLLLD_IDLE;
        end
      end
    endcase
    // Count and flag hold unless a comparison ends or detection is disabled
    hit_cnt_next = hit_cnt_reg;
    lock_next = lock_reg;
    if (!cfg_reg.enable) begin
      // Disabled: everything held clear
      state_next = PLLLD_IDLE;
      diff_next = 6'h00;
      hit_cnt_next = 16'h0000;
      lock_next = 1'b0;
    end else if (miss) begin
      hit_cnt_next = 16'h0000;
      lock_next = 1'b0;
    end else if (hit) begin
      // Saturate and declare lock at the programmed count
      if ({1'b0, hit_cnt_reg} + 17'h00001 >= hit_need) begin
        lock_next = 1'b1;
        hit_cnt_next = hit_need[15:0] == 16'h0000 ? 16'hffff : hit_need[15:0];
      end else begin
        hit_cnt_next = hit_cnt_reg + 16'h0001;
      end
    end
  end

  // Edge synchronisers; the pins are asynchronous, so two flops come before any logic
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // Both pins idle low, so no false edge follows reset
      sync_meta_reg <= 2'h0;
      sync_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else if (ce_i) begin
      // The second and third flops feed the edge detectors; the first never does
      sync_meta_reg <= phase_comparator_edge_i;
      sync_reg <= sync_meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Detector state
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // No comparison open and no lock after reset
      state_reg <= PLLLD_IDLE;
      diff_reg <= 6'h00;
      hit_cnt_reg <= 16'h0000;
      lock_reg <= 1'b0;
    end else if (ce_i) begin
      // State moves only while ce_i is high
      state_reg <= state_next;
      diff_reg <= diff_next;
      hit_cnt_reg <= hit_cnt_next;
      lock_reg <= lock_next;
    end
  end

  // Registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // Power-on configuration
      cfg_reg <= `PLLLD_LD_CFG_RST;
      pin_cfg_reg <= `PLLLD_PIN_CFG_RST;
      rdata_reg <= 24'h000000;
    end else if (ce_i) begin
      // Writes land at the edge that takes them
      if (wr_cfg) begin
        cfg_reg <= reg_wdata_i;
      end
      if (wr_pin) begin
        pin_cfg_reg <= reg_wdata_i;
      end
      // Read data is captured once and held until the next read
      if (reg_rd_i) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Lock timer clock model, slower for higher speed codes
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ring_div_reg <= 2'h0;
      ring_clk_reg <= 1'b0;
    end else if (ce_i) begin
      // Stopped while detection is off; otherwise flip after speed+1 cycles
      if (!cfg_reg.enable || ring_div_reg >= cfg_reg.timer_speed) begin
        ring_div_reg <= 2'h0;
        ring_clk_reg <= cfg_reg.enable & ~ring_clk_reg;
      end else begin
        // Still counting toward the next flip
        ring_div_reg <= ring_div_reg + 2'h1;
      end
    end
  end

  // Pin outputs
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // Pins low in reset
      pin_reg <= 1'b0;
      gpo_reg <= 1'b0;
    end else if (ce_i) begin
      // Registered so the pins never glitch
      pin_reg <= pin_value;
      gpo_reg <= gpo_value;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign lock_or_serial_out_pin_o = pin_reg;
  assign gpo_test_o = gpo_reg;
  assign lock_indicator_o = lock_reg;

  // Checks
  // Disabled detector keeps count and lock clear
  disabled_clear_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && !cfg_reg.enable) |=> (hit_cnt_reg == 16'h0000) && !lock_reg)
    else $error("count or lock not cleared while disabled");
  // Lock only rises on the hit that completes the count
  lock_needs_hits_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(lock_reg) |-> ({1'b0, $past(hit_cnt_reg)} + 17'h00001 >= $past(hit_need)))
    else $error("lock declared before enough hits");
  // A window that runs out without the partner edge is a miss
  miss_clears_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && cfg_reg.enable && state_reg != PLLLD_IDLE && !ref_rise && !div_rise
     && arrival >= {1'b0, win_cyc}) |=> !lock_reg && (hit_cnt_reg == 16'h0000))
    else $error("out-of-window comparison kept lock");
  // A partner edge that comes too late is a miss as well
  late_partner_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && cfg_reg.enable && arrival >= {1'b0, win_cyc}
     && ((state_reg == PLLLD_WAIT_DIV && div_rise) || (state_reg == PLLLD_WAIT_REF && ref_rise)))
    |=> !lock_reg && (hit_cnt_reg == 16'h0000))
    else $error("late partner edge kept lock");
  // Code zero asks for five hits
  hit_code_five_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (cfg_reg.hit_code == 3'h0) |-> (hit_need == 17'h00005))
    else $error("hit code zero does not need five hits");
  // Analog window is the fixed one-shot length
  analog_window_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !cfg_reg.digital_win |-> (win_cyc == ANALOG_CYC))
    else $error("analog window length wrong");
  // Coincident edges are a zero gap and count as a hit
  both_edges_hit_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && cfg_reg.enable && state_reg == PLLLD_IDLE && ref_rise && div_rise && !lock_reg
     && hit_cnt_reg == 16'h0000 && hit_need > 17'h00001) |=> (hit_cnt_reg == 16'h0001))
    else $error("coincident edges not counted as hit");
  // Lock holds while no comparison is open
  lock_steady_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && cfg_reg.enable && lock_reg && state_reg == PLLLD_IDLE && !ref_rise && !div_rise) |=> lock_reg)
    else $error("lock dropped without a miss");
  // Status read returns the lock flag
  status_read_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && reg_rd_i && reg_addr_i == `PLLLD_OFS_STATUS) |=> (reg_rdata_o[1] == $past(lock_reg)))
    else $error("status bit does not show lock");
  // Shared pin follows lock when lock is routed to it
  pin_lock_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && pin_lock_sel && !pin_serial) |=> (lock_or_serial_out_pin_o == $past(lock_reg)))
    else $error("pin does not follow lock");
  // Shared pin stays low when neither lock nor read data is routed to it
  pin_off_lock_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && !pin_lock_sel && !pin_serial) |=> !lock_or_serial_out_pin_o)
    else $error("pin shows lock while another source is selected");
  // Shared pin carries read data while a read shifts out
  pin_serial_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && pin_serial) |=> (lock_or_serial_out_pin_o == $past(sdo_data_i)))
    else $error("pin does not carry read data");
  // Test pin quiet unless the lock timer clock is routed to it
  gpo_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && pin_cfg_reg.out_sel != `PLLLD_PIN_SEL_TIMER) |=> !gpo_test_o)
    else $error("test pin active while not selected");
  // Lock timer clock rests low while detection is off
  timer_stopped_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ce_i && !cfg_reg.enable) |=> !ring_clk_reg)
    else $error("lock timer runs while detection is off");

endmodule // pllld_lock_detector
`default_nettype wire

//--- rtl/pllld_pkg.sv
// Types shared by the lock detector
package pllld_pkg;
  // Lock detect configuration word
  typedef struct packed {
    logic [11:0] rsvd_hi;
    logic [1:0] timer_speed;
    logic [2:0] win_duration;
    logic digital_win;
    logic [1:0] rsvd_lo;
    logic enable;
    logic [2:0] hit_code;
  } pllld_cfg_t;
  // Pin routing word
  typedef struct packed {
    logic [16:0] rsvd_hi;
    logic share_off;
    logic rsvd5;
    logic [4:0] out_sel;
  } pllld_pin_cfg_t;
  // Comparison state
  typedef enum logic [1:0] {PLLLD_IDLE, PLLLD_WAIT_DIV, PLLLD_WAIT_REF} pllld_state_t;
endpackage : pllld_pkg

//--- test/pllld_edge_src.sv
// Phase comparator edge source standing in for reference and divider
`timescale 1ns/1ns
`default_nettype none
module pllld_edge_src (
  // Clock
  input wire logic core_clk_i,
  // Edges: bit 0 reference, bit 1 divided
  output logic [1:0] edge_o
);
  // Both edges rest low between comparisons
  initial edge_o = 2'h0;
  // One comparison: first edge, a gap in cycles, then the other edge
  task automatic pulse(input int gap, input logic div_first);
    @(negedge core_clk_i);
    edge_o[div_first] = 1'b1;
    repeat (gap) @(negedge core_clk_i);
    edge_o[!div_first] = 1'b1;
    repeat (3) @(negedge core_clk_i);
    edge_o = 2'h0;
    // Quiet time lets the longest window run out
    repeat (gap + 20) @(negedge core_clk_i);
  endtask
endmodule // pllld_edge_src
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the lock detector
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pllld_pkg::*;
  // Stimulus and observed pins
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [23:0] reg_wdata_i = 24'h000000;
  logic sdo_read_active_i = 1'b0;
  logic sdo_data_i = 1'b0;
  logic [1:0] phase_comparator_edge_i;
  logic [23:0] reg_rdata_o;
  logic lock_or_serial_out_pin_o;
  logic gpo_test_o;
  logic lock_indicator_o;
  int n_fail = 0;
  int checks = 0;
  // 50 MHz clock
  always #10 core_clk_i = ~core_clk_i;
  pllld_edge_src pllld_edge_src_inst (.core_clk_i, .edge_o(phase_comparator_edge_i));
  pllld_lock_detector pllld_lock_detector_inst (.core_clk_i, .rstn_i, .ce_i, .phase_comparator_edge_i,
    .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .sdo_read_active_i, .sdo_data_i,
    .lock_or_serial_out_pin_o, .gpo_test_o, .lock_indicator_o);
  // Value compare
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  // Register write, one-cycle strobe
  task automatic wreg(input logic [7:0] a, input logic [23:0] d);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask
  // Register read, data one cycle after the read edge
  task automatic rchk(input logic [7:0] a, input logic [23:0] exp);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    @(negedge core_clk_i);
    cmp("read data", exp, reg_rdata_o);
  endtask
  // Lock seen in status, flag and shared pin
  task automatic chk_lock(input logic e);
    rchk(8'h12, {22'h0, e, 1'b0});
    cmp("lock flag", {23'h0, e}, {23'h0, lock_indicator_o});
    cmp("shared pin", {23'h0, e}, {23'h0, lock_or_serial_out_pin_o});
  endtask
  // Several comparisons with one gap
  task automatic hits(input int n, input int gap, input logic df);
    repeat (n) pllld_edge_src_inst.pulse(gap, df);
  endtask
  // Window edge: largest hit gap locks, one more misses
  task automatic t_win(input logic [23:0] cfg, input int ok);
    wreg(8'h07, cfg);
    hits(1, 40, 1'b0);
    hits(3, ok, 1'b0);
    hits(2, ok, 1'b1);
    chk_lock(1'b1);
    hits(1, ok + 1, 1'b1);
    chk_lock(1'b0);
    $display("done window %h", cfg);
  endtask
  // Hit count for codes 0 to 3
  task automatic t_codes;
    int need[4] = '{5, 32, 96, 256};
    for (int c = 0; c < 4; c++) begin
      wreg(8'h07, 24'h000148 | 24'(c));
      hits(1, 40, 1'b0);
      hits(need[c] - 1, 0, c[0]);
      chk_lock(1'b0);
      hits(1, 0, 1'b0);
      chk_lock(1'b1);
    end
    $display("done codes");
  endtask
  // Enable off clears and blocks lock
  task automatic t_enable;
    wreg(8'h07, 24'h000148);
    hits(5, 0, 1'b0);
    chk_lock(1'b1);
    wreg(8'h07, 24'h000140);
    chk_lock(1'b0);
    hits(5, 0, 1'b0);
    chk_lock(1'b0);
    $display("done enable");
  endtask
  // Shared pin during reads and timer clock on test pin
  task automatic t_pin;
    int n;
    logic prev;
    wreg(8'h07, 24'h000148);
    hits(5, 0, 1'b0);
    @(negedge core_clk_i);
    sdo_read_active_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    cmp("pin read bit", 24'h0, {23'h0, lock_or_serial_out_pin_o});
    sdo_data_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    cmp("pin read bit", 24'h1, {23'h0, lock_or_serial_out_pin_o});
    sdo_data_i = 1'b0;
    sdo_read_active_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    cmp("pin restored", 24'h1, {23'h0, lock_or_serial_out_pin_o});
    sdo_read_active_i = 1'b1;
    wreg(8'h0f, 24'h000041);
    repeat (2) @(negedge core_clk_i);
    cmp("pin unshared", 24'h1, {23'h0, lock_or_serial_out_pin_o});
    sdo_read_active_i = 1'b0;
    wreg(8'h0f, 24'h000002);
    n = 0;
    @(negedge core_clk_i);
    prev = gpo_test_o;
    repeat (32) begin
      @(negedge core_clk_i);
      if (gpo_test_o !== prev) n++;
      prev = gpo_test_o;
    end
    cmp("timer toggles", 24'h20, 24'(n));
    cmp("pin off lock", 24'h0, {23'h0, lock_or_serial_out_pin_o});
    $display("done pin");
  endtask
  // Clock enable low freezes detector and registers
  task automatic t_freeze;
    wreg(8'h0f, 24'h000001);
    @(negedge core_clk_i);
    ce_i = 1'b0;
    hits(1, 40, 1'b0);
    wreg(8'h07, 24'h000140);
    cmp("frozen lock", 24'h1, {23'h0, lock_indicator_o});
    @(negedge core_clk_i);
    ce_i = 1'b1;
    chk_lock(1'b1);
    $display("done freeze");
  endtask
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge core_clk_i);
    n_fail++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (16) @(negedge core_clk_i);
    rstn_i = 1'b1;
    rchk(8'h07, 24'h00014d);
    rchk(8'h0f, 24'h000001);
    wreg(8'h12, 24'hffffff);
    wreg(8'h30, 24'hffffff);
    rchk(8'h30, 24'h000000);
    chk_lock(1'b0);
    $display("done reset");
    t_codes();
    t_win(24'h000fc8, 15);
    t_win(24'h0003c8, 8);
    t_win(24'h000008, 0);
    t_enable();
    t_pin();
    t_freeze();
    close_out();
  end
endmodule // tb
`default_nettype wire
